// ===== include/asq_pkg.sv
// constants and types for the quad-die sram host controller
package asq_pkg;
    localparam int ADDR_W    = 21;
    localparam int WORD_A_W  = 19;
    localparam int DIE_CNT   = 4;
    localparam int LANE_CNT  = 4;
    localparam int DATA_W    = 32;
    localparam int CLK_PERIOD_NS = 10;
    // read timing, worst case of the two i/o supplies
    localparam int ADDRESS_ACCESS_TIME_NS  = 22;
    localparam int READ_CYCLE_MIN_NS       = 22;
    localparam int SELECT_OFF_FLOAT_DELAY_NS = 5;
    localparam int ENABLE_OFF_FLOAT_DELAY_NS = 6;
    // write timing
    localparam int WRITE_PULSE_MIN_NS      = 7;
    localparam int WRITE_CYCLE_MIN_NS      = 15;
    localparam int WRITE_RECOVERY_NS       = 5;
    localparam int DATA_SETUP_NS           = 6;
    localparam int ADDR_TO_END_NS          = 12;
    // least times round up, at least one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ACCESS_CYC = min_cycles(ADDRESS_ACCESS_TIME_NS) + 1;
    localparam int FLOAT_CYC  = min_cycles(ENABLE_OFF_FLOAT_DELAY_NS);
    localparam int PULSE_CYC  = min_cycles(ADDR_TO_END_NS);
    localparam int RECOV_CYC  = min_cycles(WRITE_RECOVERY_NS);
    localparam int RDCYC_CYC  = min_cycles(READ_CYCLE_MIN_NS);
    localparam int WRCYC_CYC  = min_cycles(WRITE_CYCLE_MIN_NS);
    localparam int CNT_W      = 4;
    localparam logic [3:0] DIE_NONE = 4'hF;
    typedef enum logic [5:0] {
        ASQ_IDLE  = 6'h01,
        ASQ_RACC  = 6'h02,
        ASQ_WSET  = 6'h04,
        ASQ_WPUL  = 6'h08,
        ASQ_FLOAT = 6'h10,
        ASQ_RECOV = 6'h20
    } asq_state_type;
endpackage

// ===== core/asq_wait_timer.sv
// down counter used for every timed phase of the controller
`timescale 1ns/1ns
module asq_wait_timer #(
    parameter int CW = 4
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          load,
    input  wire logic [CW-1:0] load_val,
    output logic               done
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    assign cnt_d = load ? load_val
                 : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    // no load term: callers load on done, which would close a loop
    assign done = (cnt_q == '0);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule

// ===== core/asq_sram_host.sv
// host controller driving a clockless quad-die 2m x 32 static ram
`timescale 1ns/1ns
module asq_sram_host #(
    parameter int ADDR_W = asq_pkg::ADDR_W,
    parameter int DATA_W = asq_pkg::DATA_W
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // user side
    input  wire logic                req_valid,
    input  wire logic                req_write,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [DATA_W-1:0]   req_wdata,
    input  wire logic [3:0]          req_lanes,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_rdata,
    // memory pins
    output logic [18:0]              mem_addr,
    output logic [3:0]               die_select_n,
    output logic [3:0]               byte_lane_enable_n,
    output logic                     chip_enable,
    output logic                     write_strobe_n,
    output logic                     output_drive_enable_n,
    input  wire logic [DATA_W-1:0]   mem_dq_in,
    output logic [DATA_W-1:0]        mem_dq_out,
    output logic [DATA_W-1:0]        mem_dq_oe
);
    asq_pkg::asq_state_type state_q;
    asq_pkg::asq_state_type state_d;
    logic [18:0]        addr_q;
    logic [3:0]         sel_n_q;
    logic [3:0]         lane_n_q;
    logic               ce_q;
    logic               we_n_q;
    logic               oe_n_q;
    logic [DATA_W-1:0]  dout_q;
    logic [DATA_W-1:0]  doe_q;
    logic               ready_q;
    logic               rvalid_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               tmr_load;
    logic [asq_pkg::CNT_W-1:0] tmr_val;
    logic               tmr_done;
    logic               take;
    logic [3:0]         die_sel_n;
    logic [DATA_W-1:0]  lane_mask;

    // one-hot low select from the top address bits
    function automatic logic [3:0] die_decode(input logic [1:0] d);
        die_decode = ~(4'h1 << d);
    endfunction

    assign take      = ready_q && req_valid && state_q == asq_pkg::ASQ_IDLE;
    assign die_sel_n = die_decode(req_addr[ADDR_W-1 -: 2]);
    assign lane_mask = {{8{~lane_n_q[3]}}, {8{~lane_n_q[2]}},
                        {8{~lane_n_q[1]}}, {8{~lane_n_q[0]}}};

    always_comb
    begin
        state_d  = state_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        case (state_q)
            asq_pkg::ASQ_IDLE:
                if (take && req_write)
                begin
                    state_d  = asq_pkg::ASQ_WSET;
                    tmr_load = 1'b1;
                    tmr_val  = asq_pkg::CNT_W'(asq_pkg::FLOAT_CYC);
                end
                else if (take)
                begin
                    state_d  = asq_pkg::ASQ_RACC;
                    tmr_load = 1'b1;
                    // extra cycle covers access time plus pin sampling
                    tmr_val  = asq_pkg::CNT_W'(asq_pkg::ACCESS_CYC);
                end
            asq_pkg::ASQ_RACC:
                if (tmr_done)
                begin
                    state_d  = asq_pkg::ASQ_FLOAT;
                    tmr_load = 1'b1;
                    tmr_val  = asq_pkg::CNT_W'(asq_pkg::FLOAT_CYC);
                end
            asq_pkg::ASQ_WSET:
                if (tmr_done)
                begin
                    state_d  = asq_pkg::ASQ_WPUL;
                    tmr_load = 1'b1;
                    tmr_val  = asq_pkg::CNT_W'(asq_pkg::PULSE_CYC);
                end
            asq_pkg::ASQ_WPUL:
                if (tmr_done)
                begin
                    state_d  = asq_pkg::ASQ_RECOV;
                    tmr_load = 1'b1;
                    tmr_val  = asq_pkg::CNT_W'(asq_pkg::RECOV_CYC);
                end
            asq_pkg::ASQ_FLOAT:
                if (tmr_done)
                    state_d = asq_pkg::ASQ_IDLE;
            asq_pkg::ASQ_RECOV:
                if (tmr_done)
                    state_d = asq_pkg::ASQ_IDLE;
            default:
                state_d = asq_pkg::ASQ_IDLE;
        endcase
    end

    asq_wait_timer #(
        .CW (asq_pkg::CNT_W)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_q <= asq_pkg::ASQ_IDLE;
        else
            state_q <= state_d;
    end

    // address and select latched once per access, steady across it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_q   <= '0;
            sel_n_q  <= asq_pkg::DIE_NONE;
            lane_n_q <= 4'hF;
            ce_q     <= 1'b0;
        end
        else if (take)
        begin
            addr_q   <= req_addr[18:0];
            sel_n_q  <= die_sel_n;
            lane_n_q <= ~req_lanes;
            ce_q     <= 1'b1;
        end
        else if (state_d == asq_pkg::ASQ_IDLE ||
                 state_d == asq_pkg::ASQ_FLOAT ||
                 state_d == asq_pkg::ASQ_RECOV)
        begin
            // deselect between accesses: select controlled, also ends read
            sel_n_q  <= asq_pkg::DIE_NONE;
            lane_n_q <= 4'hF;
            ce_q     <= 1'b0;
        end
    end

    // strobe low only inside the select-low window
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            we_n_q <= 1'b1;
        else
            we_n_q <= ~(state_d == asq_pkg::ASQ_WPUL);
    end

    // output drive only during the read access phase
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            oe_n_q <= 1'b1;
        else
            oe_n_q <= ~(state_d == asq_pkg::ASQ_RACC);
    end

    // write data driven after float wait, held until recovery ends
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dout_q <= '0;
            doe_q  <= '0;
        end
        else
        begin
            if (take && req_write)
                dout_q <= req_wdata;
            if (state_d == asq_pkg::ASQ_WPUL ||
                state_d == asq_pkg::ASQ_RECOV)
                doe_q <= {DATA_W{1'b1}};
            else
                doe_q <= '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ready_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
        end
        else
        begin
            // ready drops on take, so accesses never overlap
            ready_q  <= (state_d == asq_pkg::ASQ_IDLE) && !take;
            rvalid_q <= state_q == asq_pkg::ASQ_RACC && tmr_done;
            if (state_q == asq_pkg::ASQ_RACC && tmr_done)
                rdata_q <= mem_dq_in & lane_mask;
        end
    end

    assign req_ready             = ready_q;
    assign rsp_valid             = rvalid_q;
    assign rsp_rdata             = rdata_q;
    assign mem_addr              = addr_q;
    assign die_select_n          = sel_n_q;
    assign byte_lane_enable_n    = lane_n_q;
    assign chip_enable           = ce_q;
    assign write_strobe_n        = we_n_q;
    assign output_drive_enable_n = oe_n_q;
    assign mem_dq_out            = dout_q;
    assign mem_dq_oe             = doe_q;
endmodule

// ===== tb/asq_host_assertions.sv
// pin-level assertions for the quad-die sram host
`timescale 1ns/1ns
module asq_host_assertions (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic [18:0] mem_addr,
    input wire logic [3:0]  die_select_n,
    input wire logic        chip_enable,
    input wire logic        write_strobe_n,
    input wire logic        output_drive_enable_n,
    input wire logic [31:0] mem_dq_out,
    input wire logic [31:0] mem_dq_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    one_die_a: assert property ($onehot0(~die_select_n))
        else $error("two dies selected");
    strobe_frame_a: assert property (!write_strobe_n |-> chip_enable
        && die_select_n != 4'hF && output_drive_enable_n) else $error("bad strobe");
    no_fight_a: assert property (!output_drive_enable_n |->
        mem_dq_oe == 32'h0 && write_strobe_n) else $error("bus fight");
    float_first_a: assert property ($rose(|mem_dq_oe) |->
        $past(output_drive_enable_n)) else $error("drive before float");
    write_hold_a: assert property ((!write_strobe_n || $rose(write_strobe_n))
        |-> $stable(mem_addr) && $stable(mem_dq_out)) else $error("moved in write");
    pulse_width_a: assert property ($fell(write_strobe_n) |=>
        !write_strobe_n) else $error("short strobe");
    write_gap_a: assert property ($rose(write_strobe_n) |->
        write_strobe_n[*3]) else $error("short recovery");
    read_answer_a: assert property (req_valid && req_ready && !req_write
        |-> ##[5:6] rsp_valid) else $error("no read answer");
    read_late_a: assert property (rsp_valid |->
        !$past(output_drive_enable_n, 3)) else $error("sampled early");
    cover property (req_valid && req_ready && req_write);
    cover property (rsp_valid);
    cover property ($rose(write_strobe_n));
endmodule
bind asq_sram_host asq_host_assertions u_chk (.ref_clk, .rst, .req_valid,
    .req_write, .req_ready, .rsp_valid, .mem_addr, .die_select_n, .chip_enable,
    .write_strobe_n, .output_drive_enable_n, .mem_dq_out, .mem_dq_oe);

// ===== tb/asq_sram_model.sv
// behavioural quad-die static ram on the far side of the host
`timescale 1ns/1ns
module asq_sram_model (
    input  wire logic [18:0] mem_addr,
    input  wire logic [3:0]  die_select_n,
    input  wire logic [3:0]  byte_lane_enable_n,
    input  wire logic        chip_enable,
    input  wire logic        write_strobe_n,
    input  wire logic        output_drive_enable_n,
    input  wire logic [31:0] mem_dq_out,
    input  wire logic [31:0] mem_dq_oe,
    output logic [31:0]      mem_dq_in
);
    // only word bits [7:0] kept per die; tests keep addresses apart there
    logic [31:0] mem [0:1023];
    logic [31:0] word_q = 32'h0;
    logic [31:0] q;
    logic        rd;
    function automatic logic [1:0] die_idx(input logic [3:0] s);
        return !s[0] ? 2'h0 : !s[1] ? 2'h1 : !s[2] ? 2'h2 : 2'h3;
    endfunction
    initial
        for (int i = 0; i < 1024; i++)
            mem[i] = 32'hA5C3_5A3C;
    // no clock: pin levels alone pick the mode
    assign rd = die_select_n != 4'hF && chip_enable && write_strobe_n;
    // old word lingers an access time, so early sampling shows stale data
    always @(mem_addr or die_select_n or chip_enable)
        word_q <= #(asq_pkg::ADDRESS_ACCESS_TIME_NS)
            mem[{die_idx(die_select_n), mem_addr[7:0]}];
    // floated lanes show the inverse, never a lucky match
    always @*
        for (int b = 0; b < 4; b++)
            q[8*b +: 8] = (rd && !output_drive_enable_n
                && !byte_lane_enable_n[b]) ? word_q[8*b +: 8]
                : ~word_q[8*b +: 8];
    assign mem_dq_in = (mem_dq_oe & mem_dq_out) | (~mem_dq_oe & q);
    // level-sensitive store; deselect ends it at once
    always @(die_select_n or chip_enable or write_strobe_n or mem_addr
        or byte_lane_enable_n or mem_dq_in)
    begin : store
        logic [31:0] w;
        logic [9:0]  k;
        k = {die_idx(die_select_n), mem_addr[7:0]};
        w = mem[k];
        if (chip_enable && !write_strobe_n && die_select_n != 4'hF)
        begin
            for (int b = 0; b < 4; b++)
                if (!byte_lane_enable_n[b])
                    w[8*b +: 8] = mem_dq_in[8*b +: 8];
            mem[k] = w;
        end
    end
endmodule

// ===== tb/asq_tb.sv
// self-checking bench for the quad-die sram host
`timescale 1ns/1ns
module tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [20:0] req_addr = 21'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [3:0]  req_lanes = 4'h0;
    logic        req_ready, rsp_valid, chip_enable, write_strobe_n;
    logic        output_drive_enable_n;
    logic [31:0] rsp_rdata, mem_dq_in, mem_dq_out, mem_dq_oe;
    logic [18:0] mem_addr;
    logic [3:0]  die_select_n, byte_lane_enable_n;
    logic [12:0] pins;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    assign pins = {die_select_n, byte_lane_enable_n, chip_enable,
        write_strobe_n, output_drive_enable_n, rsp_valid, req_ready};
    asq_sram_host uut (.ref_clk, .rst, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_lanes, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
        .die_select_n, .byte_lane_enable_n, .chip_enable, .write_strobe_n,
        .output_drive_enable_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
    asq_sram_model u_mem (.mem_addr, .die_select_n, .byte_lane_enable_n,
        .chip_enable, .write_strobe_n, .output_drive_enable_n, .mem_dq_out,
        .mem_dq_oe, .mem_dq_in);
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // tests need about a hundred cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // held from a negedge with ready high, so the next edge takes it
    task automatic access(input logic wr, input logic [20:0] a,
        input logic [31:0] d, input logic [3:0] ln, output logic [31:0] q);
        for (int n = 0; n < 40 && req_ready !== 1'b1; n++)
            @(negedge ref_clk);
        if (req_ready !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t request never accepted", $time);
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lanes = ln;
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (int n = 0; n < 20 && !wr && rsp_valid !== 1'b1; n++)
            @(negedge ref_clk);
        if (!wr && rsp_valid !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t no read answer", $time);
        end
        q = rsp_rdata;
    endtask
    task automatic t_reset();
        chk({19'h0, pins}, 32'h0000_1FEC);
        chk(mem_dq_oe, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_dies();
        logic [31:0] q;
        for (int d = 0; d < 4; d++)
            access(1'b1, {d[1:0], 19'h2A5A5}, 32'hC0DE_0000 + d, 4'hF, q);
        for (int d = 0; d < 4; d++)
        begin
            access(1'b0, {d[1:0], 19'h2A5A5}, 32'h0, 4'hF, q);
            chk(q, 32'hC0DE_0000 + d);
        end
        $display("die test done");
    endtask
    task automatic t_lanes();
        logic [31:0] q;
        access(1'b1, 21'h1F_0123, 32'h1122_3344, 4'hF, q);
        access(1'b1, 21'h1F_0123, 32'hFFFF_FFFF, 4'h6, q);
        access(1'b0, 21'h1F_0123, 32'h0, 4'hF, q);
        chk(q, 32'h11FF_FF44);
        access(1'b0, 21'h1F_0123, 32'h0, 4'h9, q);
        chk(q, 32'h1100_0044);
        $display("lane test done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge ref_clk);
        t_reset();
        rst = 1'b0;
        t_dies();
        t_lanes();
        end_sim();
    end
endmodule
